/* sadc_pkg.sv */
/*
 * constants, state encoding and the gain table of the converter's
 * conversion and readout control.
 * assumes a 10 MHz core clock; all times are turned into cycles of it here.
 */
package sadc_pkg;
    // core clock period
    localparam int CLK_PERIOD_NS = 100;
    // longest busy-high times; longest times round down to whole cycles
    localparam int BUSY_BYP_NS = 660;
    localparam int BUSY_AMP_NS = 1550;
    localparam int CONV_BYP_RAW = BUSY_BYP_NS / CLK_PERIOD_NS;
    localparam int CONV_AMP_RAW = BUSY_AMP_NS / CLK_PERIOD_NS;
    localparam logic [3:0] CONV_BYP_CYC = 4'(CONV_BYP_RAW < 1 ? 1 : CONV_BYP_RAW);
    localparam logic [3:0] CONV_AMP_CYC = 4'(CONV_AMP_RAW < 1 ? 1 : CONV_AMP_RAW);
    // wake time after power-down release; least time rounds up
    localparam int T_WAKE_NS = 25000;
    localparam logic [7:0] WAKE_CYC = 8'((T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // result and trailer layout
    localparam int RESULT_W = 14;
    localparam int SEL_W = 3;
    localparam int SHIFT_W = RESULT_W + 2 * SEL_W;
    // synchronised pin bundle: positions inside the synchroniser vector
    localparam int SY_CS = 0;
    localparam int SY_SCK = 1;
    localparam int SY_PWR = 2;
    localparam int SY_LOWP = 3;
    localparam int SY_BYP = 4;
    localparam int SY_SCAN = 5;
    localparam int SY_CH = 6;
    localparam int SY_GN = 9;
    localparam int SY_W = 12;
    // gain decode table, code 0..7
    localparam logic [4:0] GAIN_X1 = 5'h01;
    localparam logic [4:0] GAIN_X2 = 5'h02;
    localparam logic [4:0] GAIN_X3 = 5'h03;
    localparam logic [4:0] GAIN_X4 = 5'h04;
    localparam logic [4:0] GAIN_X6 = 5'h06;
    localparam logic [4:0] GAIN_X8 = 5'h08;
    localparam logic [4:0] GAIN_X12 = 5'h0C;
    localparam logic [4:0] GAIN_X16 = 5'h10;
    // conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_READ
    } sadc_state_t;
endpackage : sadc_pkg

/* sadc_sync.sv */
/*
 * two-flop synchroniser for the pin inputs of the converter control.
 * assumes the inputs are asynchronous levels; outputs are in core_clk domain.
 */
`timescale 1ns/1ps
module sadc_sync (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [sadc_pkg::SY_W-1:0] pinIn,
    output logic [sadc_pkg::SY_W-1:0] pinSync
);
    import sadc_pkg::*;

    // all state of the synchroniser
    typedef struct packed {
        logic [SY_W-1:0] stage1; // first flop, read only by stage2
        logic [SY_W-1:0] stage2; // settled copy
    } sadc_sync_t;

    sadc_sync_t r;
    sadc_sync_t next_r;

    // one flop pair per bit
    genvar b;
    generate
        for (b = 0; b < SY_W; b++) begin : g_bit
            always_comb begin
                next_r.stage1[b] = pinIn[b];
                next_r.stage2[b] = r.stage1[b];
            end
        end
    endgenerate

    // register the copy; reset value is idle (chip select high, powered)
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            r <= '{stage1: 12'h0005, stage2: 12'h0005};
        end else begin
            r <= next_r;
        end
    end

    assign pinSync = r.stage2;
endmodule : sadc_sync

/* sadc_conv.sv */
/*
 * conversion and serial readout control of an eight-channel 14-bit
 * successive-approximation converter: busy timing, result shifter,
 * channel/gain capture, scan sequencing and wake-up from power-down.
 * assumes the analog core hands a settled code on sampleData whenever
 * busy falls, and that the host drives chip select and serial clock slowly
 * enough for the 10 MHz core clock to see every edge.
 */
// Notes on behaviour
// [RULE1] host limits normal-mode start rate
// [RULE2] host limits low-power start rate
// [RULE3] busy drops by 660 ns, amp bypassed
// [RULE4] busy drops by 1550 ns, amp used
// [RULE5] busy rises promptly after select falls
// [RULE6] host keeps select-high and quiet gaps
// [RULE7] first result bit shown by busy fall
// [RULE8] each serial clock rise shifts next bit
// [RULE9] data driven while select low only
// [RULE10] gain and channel captured at select rise
// [RULE11] scan input captured at select rise
// [RULE12] host waits 25 us after power-up
// [RULE13] trailing select bits are optional
// [RULE14] host may stop clocking after result
// [RULE15] select fall samples and starts conversion
// [RULE16] gain codes map to 1..16
// [RULE17] low-power pin selects power mode
// [RULE18] current result read, no pipeline delay
// [RULE19] result shifted msb first
// [RULE20] channel code is binary index, next sample
`timescale 1ns/1ps
module sadc_conv (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic chipSelectN, // pin, active low
    input wire logic serialClk, // pin, host serial clock
    input wire logic powerDownN, // pin, active low sleep
    input wire logic lowPowerSelect, // pin, high selects low-power mode
    input wire logic ampBypassSelect, // pin, high bypasses the amplifier
    input wire logic scanSelect, // pin, scan sequencer enable
    input wire logic [sadc_pkg::SEL_W-1:0] channelSelect, // pin
    input wire logic [sadc_pkg::SEL_W-1:0] gainSelect, // pin
    input wire logic [sadc_pkg::RESULT_W-1:0] sampleData, // from analog core
    output logic busy,
    output logic serialDataOut,
    output logic serialDataOe,
    output logic sampleStrobe, // one-cycle pulse to the analog core
    output logic [sadc_pkg::SEL_W-1:0] activeChannel,
    output logic [4:0] gainFactor,
    output logic lowPowerMode,
    output logic ampBypassed,
    output logic awake
);
    import sadc_pkg::*;

    // every piece of state of the block except the pin synchroniser flops in u_sync
    typedef struct packed {
        sadc_state_t st;
        logic [3:0] convCnt; // busy cycles still to go
        logic [SHIFT_W-1:0] shiftReg; // result then channel then gain
        logic csPrev; // for select edge detection
        logic sckPrev; // for serial clock edge detection
        logic busy;
        logic sdo;
        logic oe;
        logic [SEL_W-1:0] chan; // channel used by the next sample
        logic [SEL_W-1:0] gain; // gain code used by the next sample
        logic [SEL_W-1:0] convChan; // channel of the running conversion
        logic [SEL_W-1:0] convGain; // gain of the running conversion
        logic scan;
        logic bypass; // amplifier path latched at sample time
        logic lowPwr; // synced power mode pin
        logic [7:0] wakeCnt;
        logic awake;
        logic strobe;
    } sadc_conv_t;

    sadc_conv_t r;
    sadc_conv_t next_r;
    logic [SY_W-1:0] pinIn;
    logic [SY_W-1:0] pinSync;
    logic csFall;
    logic csRise;
    logic sckRise;

    // gain code to amplifier factor
    function automatic logic [4:0] gainDecode(input logic [SEL_W-1:0] code);
        logic [4:0] f;
        f = GAIN_X1;
        case (code)
            3'h0: f = GAIN_X1;
            3'h1: f = GAIN_X2;
            3'h2: f = GAIN_X3;
            3'h3: f = GAIN_X4;
            3'h4: f = GAIN_X6;
            3'h5: f = GAIN_X8;
            3'h6: f = GAIN_X12;
            default: f = GAIN_X16;
        endcase
        return f;
    endfunction : gainDecode

    // every pin passes two flops before the logic looks at it
    assign pinIn = {gainSelect, channelSelect, scanSelect, ampBypassSelect, lowPowerSelect, powerDownN,
                    serialClk, chipSelectN};

    sadc_sync u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pinIn(pinIn),
        .pinSync(pinSync)
    );

    // edges of the settled select and serial clock
    assign csFall = r.csPrev && !pinSync[SY_CS];
    assign csRise = !r.csPrev && pinSync[SY_CS];
    assign sckRise = !r.sckPrev && pinSync[SY_SCK];

    // next-state logic
    always_comb begin
        next_r = r;
        next_r.csPrev = pinSync[SY_CS];
        next_r.sckPrev = pinSync[SY_SCK];
        next_r.strobe = 1'b0;
        next_r.lowPwr = pinSync[SY_LOWP]; // [RULE17]
        // wake timer; the host is expected to honour it, we also gate on it [RULE12]
        // counting restarts from zero on every sleep, so a short dip costs a full wake time
        if (!pinSync[SY_PWR]) begin
            next_r.wakeCnt = 8'h00;
            next_r.awake = 1'b0;
        end else if (!r.awake) begin
            if (r.wakeCnt == WAKE_CYC - 8'h01) begin
                next_r.awake = 1'b1;
            end
            next_r.wakeCnt = r.wakeCnt + 8'h01;
        end
        case (r.st)
            ST_IDLE: begin
                // select fall takes the sample and starts converting [RULE15]
                // a fall while asleep is dropped; the host has to wait for the wake count
                if (csFall && r.awake && pinSync[SY_PWR]) begin
                    next_r.strobe = 1'b1;
                    next_r.busy = 1'b1; // [RULE5]
                    next_r.oe = 1'b1; // [RULE9]
                    next_r.bypass = pinSync[SY_BYP];
                    next_r.convChan = r.chan;
                    next_r.convGain = r.gain;
                    // amplifier path picks the busy-high length [RULE3] [RULE4]
                    next_r.convCnt = (pinSync[SY_BYP] ? CONV_BYP_CYC : CONV_AMP_CYC) - 4'h1;
                    next_r.st = ST_CONV;
                end
            end
            ST_CONV: begin
                if (csRise || !pinSync[SY_PWR]) begin
                    // aborted conversion: release everything
                    // no half-loaded word is left behind, the next select fall starts clean
                    next_r.busy = 1'b0;
                    next_r.oe = 1'b0;
                    next_r.st = ST_IDLE;
                end else if (r.convCnt == 4'h0) begin
                    // this conversion's own code, msb shown as busy drops [RULE18] [RULE7] [RULE19]
                    next_r.shiftReg = {sampleData, r.convChan, r.convGain};
                    next_r.sdo = sampleData[RESULT_W-1];
                    next_r.busy = 1'b0;
                    next_r.st = ST_READ;
                end else begin
                    next_r.convCnt = r.convCnt - 4'h1;
                end
            end
            ST_READ: begin
                if (csRise || !pinSync[SY_PWR]) begin
                    // host may stop early; trailer bits need not be read [RULE13] [RULE14]
                    // busy is already low here, only the data pin has to be let go
                    next_r.oe = 1'b0; // [RULE9]
                    next_r.st = ST_IDLE;
                end else if (sckRise) begin
                    // advance one bit per serial clock rise, zeros fill in [RULE8]
                    next_r.shiftReg = {r.shiftReg[SHIFT_W-2:0], 1'b0};
                    next_r.sdo = r.shiftReg[SHIFT_W-2];
                end
            end
            default: begin
                next_r.st = ST_IDLE;
                next_r.busy = 1'b0;
                next_r.oe = 1'b0;
            end
        endcase
        // channel and gain selects and scan are taken on every select rise, for the next sample [RULE10] [RULE11]
        if (csRise) begin
            next_r.scan = pinSync[SY_SCAN];
            next_r.gain = pinSync[SY_GN+SEL_W-1:SY_GN];
            // scan steps on from the last used channel, else binary pin index [RULE20]
            if (pinSync[SY_SCAN]) begin
                next_r.chan = r.convChan + 3'h1;
            end else begin
                next_r.chan = pinSync[SY_CH+SEL_W-1:SY_CH];
            end
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            r <= '{st: ST_IDLE, convCnt: 4'h0, shiftReg: 20'h0_0000, csPrev: 1'b1, sckPrev: 1'b0,
                   busy: 1'b0, sdo: 1'b0, oe: 1'b0, chan: 3'h0, gain: 3'h0, convChan: 3'h0,
                   convGain: 3'h0, scan: 1'b0, bypass: 1'b1, lowPwr: 1'b0, wakeCnt: 8'h00,
                   awake: 1'b0, strobe: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // outputs, all from flops except gainFactor, decoded from the convGain flops
    assign busy = r.busy;
    assign serialDataOut = r.sdo;
    assign serialDataOe = r.oe;
    assign sampleStrobe = r.strobe;
    assign activeChannel = r.convChan;
    assign gainFactor = gainDecode(r.convGain); // [RULE16]
    assign lowPowerMode = r.lowPwr;
    assign ampBypassed = r.bypass;
    assign awake = r.awake;
endmodule : sadc_conv

/* sadc_conv_properties.sv */
/* timing checker for sadc_conv: busy, strobe, pin enable, data bits.
   assumes it is bound to sadc_conv and sees its ports only. */
`timescale 1ns/1ps
module sadc_conv_properties (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic chipSelectN,
    input wire logic serialClk,
    input wire logic [sadc_pkg::RESULT_W-1:0] sampleData,
    input wire logic busy,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    input wire logic sampleStrobe,
    input wire logic ampBypassed
);
    import sadc_pkg::*;
    // cycles busy has been high, cleared while low
    logic [4:0] busyCnt;
    always_ff @(posedge core_clk) begin
        busyCnt <= (sys_rst || !busy) ? 5'h00 : busyCnt + 5'h01;
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    busy_rise_a: assert property ($fell(chipSelectN) |-> ##[1:4] busy)
        else $error("busy late after select fall");
    strobe_pulse_a: assert property ($rose(busy) |-> sampleStrobe ##1 !sampleStrobe)
        else $error("sample strobe not one cycle");
    drive_on_a: assert property (busy |-> serialDataOe)
        else $error("data pin not driven in conversion");
    drive_off_a: assert property ($rose(chipSelectN) |-> ##[1:4] !serialDataOe)
        else $error("data pin not released");
    bypass_time_a: assert property ($fell(busy) && ampBypassed |-> busyCnt == 5'(CONV_BYP_CYC))
        else $error("busy length wrong, bypassed");
    amp_time_a: assert property ($fell(busy) && !ampBypassed |-> busyCnt == 5'(CONV_AMP_CYC))
        else $error("busy length wrong, amplifier");
    first_bit_a: assert property ($fell(busy) |-> serialDataOut == sampleData[RESULT_W-1])
        else $error("first bit not shown at busy fall");
    shift_edge_a: assert property ($changed(serialDataOut) && serialDataOe && $past(serialDataOe)
        && !$fell(busy) |-> $past(serialClk, 2))
        else $error("data moved without clock rise");
    cover property ($fell(busy) && ampBypassed);
    cover property ($fell(busy) && !ampBypassed);
    cover property ($rose(chipSelectN) && serialDataOe);
endmodule : sadc_conv_properties

/* sadc_host_model.sv */
/* host model: drives chip select and serial clock, reads the data pin.
   assumes core_clk paces it; the bench calls its tasks. */
`timescale 1ns/1ps
module sadc_host_model (
    input wire logic core_clk,
    input wire logic busy,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    output logic chipSelectN,
    output logic serialClk
);
    // a released pin reads as the inverse, so stale data cannot pass
    logic pinSeen;
    assign pinSeen = serialDataOe ? serialDataOut : ~serialDataOut;
    initial begin
        chipSelectN = 1'b1;
        serialClk = 1'b0;
    end
    // all pin changes land 1 ns after the core edge
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick
    // one frame: gap, select, wait busy, then nBits msb first
    task automatic xfer(input int nBits, output logic [19:0] got, output int busyCyc);
        int k;
        got = 20'h0_0000;
        busyCyc = 0;
        repeat (10) tick(); // 1 us high and clock low
        chipSelectN = 1'b0;
        for (k = 0; k < 8 && busy !== 1'b1; k++) tick();
        while (busy === 1'b1 && busyCyc < 40) begin
            tick();
            busyCyc++;
        end
        got[19] = pinSeen;
        // 800 ns serial clock, sampled just before each rise
        for (k = 1; k < nBits; k++) begin
            serialClk = 1'b1;
            repeat (4) tick();
            serialClk = 1'b0;
            repeat (4) tick();
            got[19-k] = pinSeen;
        end
        chipSelectN = 1'b1; // trailer may be skipped
    endtask : xfer
endmodule : sadc_host_model

/* test_sar_adc_conversion_readout_timing.sv */
/* testbench of sadc_conv: random frames through the host model.
   assumes sadc_pkg, sadc_conv and the checker are compiled first. */
`timescale 1ns/1ps
module test_sar_adc_conversion_readout_timing;
    import sadc_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, powerDownN = 1'b1, lowPowerSelect = 1'b0;
    logic ampBypassSelect = 1'b1, scanSelect = 1'b0, capScan = 1'b0;
    logic [2:0] channelSelect = 3'h0, gainSelect = 3'h0, capCh = 3'h0, capGn = 3'h0, lastCh = 3'h0, expCh;
    logic [13:0] sampleData = 14'h0000;
    logic chipSelectN, serialClk, busy, serialDataOut, serialDataOe, sampleStrobe, lowPowerMode, ampBypassed, awake;
    logic [2:0] activeChannel;
    logic [4:0] gainFactor;
    logic [19:0] got;
    int nFail = 0, samplesChecked = 0, busyCyc, nBits, i;
    sadc_conv uut (.core_clk(core_clk), .sys_rst(sys_rst), .chipSelectN(chipSelectN), .serialClk(serialClk),
        .powerDownN(powerDownN), .lowPowerSelect(lowPowerSelect), .ampBypassSelect(ampBypassSelect),
        .scanSelect(scanSelect), .channelSelect(channelSelect), .gainSelect(gainSelect), .sampleData(sampleData),
        .busy(busy), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe), .sampleStrobe(sampleStrobe),
        .activeChannel(activeChannel), .gainFactor(gainFactor), .lowPowerMode(lowPowerMode),
        .ampBypassed(ampBypassed), .awake(awake));
    sadc_host_model host (.core_clk(core_clk), .busy(busy), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .chipSelectN(chipSelectN), .serialClk(serialClk));
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    // gain table 1,2,3,4 then 6,8,12,16
    function automatic logic [4:0] gainOf(input logic [2:0] c);
        return c[2] ? 5'((c[0] ? 8 : 6) << c[1]) : 5'(c) + 5'h01;
    endfunction : gainOf
    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : reportAndStop
    // watchdog: the frames need well under 1 ms
    initial begin
        #3000000;
        nFail++;
        reportAndStop();
    end
    initial begin
        void'($urandom(32'h569e_4213));
        repeat (4) host.tick();
        sys_rst = 1'b0;
        check("resetOut", {busy, serialDataOe, ampBypassed, gainFactor}, {3'h1, 5'h01});
        // sleep, then the wake count must run again before any frame
        powerDownN = 1'b0;
        repeat (5) host.tick();
        check("asleep", awake, 1'b0);
        powerDownN = 1'b1;
        for (i = 0; i < 400 && awake !== 1'b1; i++) host.tick();
        check("wakeCycles", i >= 250 && i <= 256, 1'b1);
        for (i = 0; i < 14; i++) begin
            expCh = capScan ? lastCh + 3'h1 : capCh; // scan wraps 7 to 0
            channelSelect = (i == 1) ? 3'h7 : 3'($urandom);
            gainSelect = 3'(i);
            scanSelect = (i == 2) || (i > 2 && $urandom_range(1) == 1);
            ampBypassSelect = 1'($urandom);
            lowPowerSelect = 1'($urandom);
            sampleData = 14'($urandom);
            nBits = (i % 3 == 0) ? 14 : 20;
            host.xfer(nBits, got, busyCyc);
            check("result", got[19:6], sampleData);
            check("busyCycles", 20'(busyCyc), 20'(ampBypassSelect ? CONV_BYP_CYC : CONV_AMP_CYC));
            check("channel", activeChannel, expCh);
            check("gain", gainFactor, gainOf(capGn));
            check("modes", {ampBypassed, lowPowerMode}, {ampBypassSelect, lowPowerSelect});
            if (nBits == 20) begin
                check("trailer", got[5:0], {expCh, capGn});
            end
            repeat (4) host.tick();
            check("released", serialDataOe, 1'b0);
            lastCh = expCh;
            capCh = channelSelect;
            capGn = gainSelect;
            capScan = scanSelect;
        end
        reportAndStop();
    end
endmodule : test_sar_adc_conversion_readout_timing
bind sadc_conv sadc_conv_properties chk (.core_clk(core_clk), .sys_rst(sys_rst), .chipSelectN(chipSelectN),
    .serialClk(serialClk), .sampleData(sampleData), .busy(busy), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe), .sampleStrobe(sampleStrobe), .ampBypassed(ampBypassed));
